/* pcpt_core.sv */
// Fixed-frequency peak-current pulse-width timing core with blanking and jitter
//
// Overview of operation
// - Gate turns on only at oscillator tick
// - Current-above-feedback trip ends the pulse
// - Feedback comparator ignored during blanking interval
// - Every pulse lasts at least the blanking interval
// - Gate forced off at three quarters period
// - Nominal frequency; reduce below 1.7 V feedback
// - Reduced frequency clamps at floor frequency
// - Slope ramp beyond 40 percent on-time
// - No slope compensation in burst mode
// - Four percent jitter, pattern every 4 ms
// - Jitter off in soft-start, on afterward
// - Peak current limit trip ends pulse after synchroniser delay
// - Limit comparator also blanked after turn-on
// - Limit curve chosen by 40 percent on-time
// - Reduced delay compensation during burst mode
// - Soft-start ends when the 12 ms timer has run and soft-start done is set
`timescale 1ns/10ps
`include "pcpt_regs.svh"
module pcpt_core #(
  parameter int NOM_KHZ = `PCPT_NOM_KHZ,
  parameter int FLOOR_KHZ = `PCPT_FLOOR_KHZ,
  parameter int SS_CYCLES = `PCPT_SOFT_START_MS * `PCPT_CLK_MHZ * 1000,
  parameter int JIT_CYCLES = `PCPT_JITTER_MS * `PCPT_CLK_MHZ * 1000
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic current_above_feedback,
  input wire logic peak_current_limit_trip,
  input wire logic soft_start_done,
  input wire logic burst_low_power_mode,
  input wire logic [3:0] feedback_level,
  output logic gate_drive,
  output logic slope_comp_active,
  output logic [11:0] slope_ramp,
  output logic limit_curve_high_duty,
  output logic prop_comp_reduced,
  output logic jitter_active
);
  localparam int NOM_PERIOD = `PCPT_CLK_MHZ * 1000 / NOM_KHZ;
  localparam int FLOOR_PERIOD = `PCPT_CLK_MHZ * 1000 / FLOOR_KHZ;
  localparam int BLANK_CYC = (`PCPT_BLANK_NS * `PCPT_CLK_MHZ + 999) / 1000;
  localparam int KNEE_CODE = (`PCPT_KNEE_MV + `PCPT_FB_MV_PER_CODE - 1) / `PCPT_FB_MV_PER_CODE;
  localparam int JIT_AMP = NOM_PERIOD * `PCPT_JITTER_PCT / 100;
  localparam int JIT_STEP = JIT_CYCLES / (4 * JIT_AMP);

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage sampling of asynchronous inputs; a change is taken only once
  // stages two and three agree, which also rejects one-cycle comparator chatter
  logic [3:0] async_in;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync3_reg;
  logic [3:0] clean_reg;
  logic [3:0] clean_next;
  assign async_in = {burst_low_power_mode, soft_start_done, peak_current_limit_trip,
                     current_above_feedback};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_comb begin
        clean_next[gi] = clean_reg[gi];
        if (sync2_reg[gi] == sync3_reg[gi]) begin
          clean_next[gi] = sync3_reg[gi];
        end
      end

      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
          clean_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= async_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          clean_reg[gi] <= clean_next[gi];
        end
      end
    end
  endgenerate

  logic pwm_trip;
  logic limit_trip;
  logic ss_done_in;
  logic burst;
  assign pwm_trip = clean_reg[0];
  assign limit_trip = clean_reg[1];
  assign ss_done_in = clean_reg[2];
  assign burst = clean_reg[3];

  ////////////////////////////////////////////////////////////////////////////
  // Soft-start timer; normal operation needs both the timer and the done input
  logic [23:0] ss_cnt_reg;
  logic [23:0] ss_cnt_next;
  logic normal_reg;
  logic normal_next;

  always_comb begin
    ss_cnt_next = ss_cnt_reg;
    if (ss_cnt_reg != 24'(SS_CYCLES)) begin
      ss_cnt_next = ss_cnt_reg + 24'h000001;
    end
    normal_next = (ss_cnt_reg == 24'(SS_CYCLES)) && ss_done_in;
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ss_cnt_reg <= 24'h000000;
      normal_reg <= 1'b0;
    end else begin
      ss_cnt_reg <= ss_cnt_next;
      normal_reg <= normal_next;
    end
  end

  pcpt_pkg::pcpt_jitter_type jit_offset;

  pcpt_jitter #(
    .AMP_CYC(JIT_AMP),
    .STEP_CYC(JIT_STEP)
  ) u_jitter (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .enable(normal_reg),
    .offset(jit_offset)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Feedback-to-period lookup: full rate above the knee, longer period per
  // code below it, clamped at the floor period
  function automatic pcpt_pkg::pcpt_period_type period_lookup(input logic [3:0] code);
    logic [15:0] longer;
    longer = 16'h0000;
    if (int'(code) >= KNEE_CODE) begin
      period_lookup = 12'(NOM_PERIOD);
    end else begin
      longer = 16'(NOM_PERIOD) + 16'((KNEE_CODE - int'(code)) * `PCPT_REDUCE_STEP_CYC);
      if (longer > 16'(FLOOR_PERIOD)) begin
        period_lookup = 12'(FLOOR_PERIOD);
      end else begin
        period_lookup = longer[11:0];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Period counter and gate state; limits are latched per period so that a
  // feedback change mid-pulse cannot move the duty limit under a running pulse
  pcpt_pkg::pcpt_phase_type phase_reg;
  pcpt_pkg::pcpt_phase_type phase_next;
  logic [11:0] cnt_reg;
  logic [11:0] cnt_next;
  logic [11:0] period_reg;
  logic [11:0] period_next;
  logic [11:0] dmax_reg;
  logic [11:0] dmax_next;
  logic [11:0] p40_reg;
  logic [11:0] p40_next;
  logic [13:0] period_jit;
  logic tick;

  assign tick = (cnt_reg == period_reg - 12'h001);

  always_comb begin
    cnt_next = cnt_reg + 12'h001;
    period_next = period_reg;
    dmax_next = dmax_reg;
    p40_next = p40_reg;
    phase_next = phase_reg;
    period_jit = 14'($signed({2'b00, period_lookup(feedback_level)}) + 14'(jit_offset));
    if (tick) begin
      cnt_next = 12'h000;
      period_next = period_jit[11:0];
      // Products are formed at 20 bits: 14 bits overflow at 40 % of any real period
      dmax_next = 12'((20'(period_jit) * 20'(`PCPT_MAX_DUTY_NUM)) / 20'(`PCPT_MAX_DUTY_DEN));
      p40_next = 12'((20'(period_jit) * 20'(`PCPT_SLOPE_PCT)) / 20'h00064);
      phase_next = pcpt_pkg::PCPT_BLANK;
    end else begin
      case (phase_reg)
        pcpt_pkg::PCPT_BLANK: begin
          // Trips are masked here, so the pulse lasts BLANK_CYC at least
          if (cnt_reg >= dmax_reg - 12'h001) begin
            phase_next = pcpt_pkg::PCPT_OFF;
          end else if (cnt_reg >= 12'(BLANK_CYC - 1)) begin
            phase_next = pcpt_pkg::PCPT_ARMED;
          end
        end
        pcpt_pkg::PCPT_ARMED: begin
          if (limit_trip) begin
            phase_next = pcpt_pkg::PCPT_OFF;
          end else if (pwm_trip) begin
            phase_next = pcpt_pkg::PCPT_OFF;
          end else if (cnt_reg >= dmax_reg - 12'h001) begin
            phase_next = pcpt_pkg::PCPT_OFF;
          end
        end
        default: begin
          phase_next = pcpt_pkg::PCPT_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= pcpt_pkg::PCPT_OFF;
      cnt_reg <= 12'h000;
      period_reg <= 12'(NOM_PERIOD);
      dmax_reg <= 12'(NOM_PERIOD * `PCPT_MAX_DUTY_NUM / `PCPT_MAX_DUTY_DEN);
      p40_reg <= 12'(NOM_PERIOD * `PCPT_SLOPE_PCT / 100);
    end else begin
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      period_reg <= period_next;
      dmax_reg <= dmax_next;
      p40_reg <= p40_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs: gate, slope ramp and current-limit curve selection
  logic gate_next;
  logic slope_act_next;
  logic [11:0] ramp_next;
  logic curve_next;
  logic past40;

  always_comb begin
    gate_next = (phase_next != pcpt_pkg::PCPT_OFF);
    past40 = (phase_next != pcpt_pkg::PCPT_OFF) && (cnt_next > p40_next);
    slope_act_next = past40 && !burst;
    ramp_next = 12'h000;
    if (slope_act_next) begin
      ramp_next = cnt_next - p40_next;
    end
    // Curve holds its choice after turn-off until the next tick clears it
    curve_next = limit_curve_high_duty;
    if (tick) begin
      curve_next = 1'b0;
    end else if (past40) begin
      curve_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gate_drive <= 1'b0;
      slope_comp_active <= 1'b0;
      slope_ramp <= 12'h000;
      limit_curve_high_duty <= 1'b0;
      prop_comp_reduced <= 1'b0;
      jitter_active <= 1'b0;
    end else begin
      gate_drive <= gate_next;
      slope_comp_active <= slope_act_next;
      slope_ramp <= ramp_next;
      limit_curve_high_duty <= curve_next;
      prop_comp_reduced <= burst;
      jitter_active <= normal_reg;
    end
  end
endmodule

/* pcpt_regs.svh */
// Constants for the peak-current pulse-width timing core
`ifndef PCPT_REGS_SVH
`define PCPT_REGS_SVH
`define PCPT_CLK_MHZ 100
`define PCPT_NOM_KHZ 100
`define PCPT_FLOOR_KHZ 66
`define PCPT_FB_MV_PER_CODE 250
`define PCPT_KNEE_MV 1700
`define PCPT_REDUCE_STEP_CYC 100
`define PCPT_BLANK_NS 300
`define PCPT_MAX_DUTY_NUM 3
`define PCPT_MAX_DUTY_DEN 4
`define PCPT_SLOPE_PCT 40
`define PCPT_JITTER_PCT 4
`define PCPT_JITTER_MS 4
`define PCPT_SOFT_START_MS 12
`define PCPT_SOFT_START_STEPS 4
`endif

/* pcpt_pkg.sv */
// Types shared by the peak-current pulse-width timing core
package pcpt_pkg;
  typedef enum logic [1:0] {
    PCPT_OFF = 2'b00,
    PCPT_BLANK = 2'b01,
    PCPT_ARMED = 2'b10
  } pcpt_phase_type;
  typedef logic signed [7:0] pcpt_jitter_type;
  typedef logic [11:0] pcpt_period_type;
endpackage

/* pcpt_jitter.sv */
// Triangle jitter offset generator for the switching period
`timescale 1ns/10ps
module pcpt_jitter #(
  parameter int AMP_CYC = 40,
  parameter int STEP_CYC = 2500
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic enable,
  output pcpt_pkg::pcpt_jitter_type offset
);
  logic [15:0] div_reg;
  logic [15:0] div_next;
  pcpt_pkg::pcpt_jitter_type off_reg;
  pcpt_pkg::pcpt_jitter_type off_next;
  logic up_reg;
  logic up_next;
  localparam pcpt_pkg::pcpt_jitter_type AMP = pcpt_pkg::pcpt_jitter_type'(AMP_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // Walk 0 -> +AMP -> -AMP -> 0; four ramps of AMP steps make one pattern
  always_comb begin
    div_next = div_reg;
    off_next = off_reg;
    up_next = up_reg;
    if (!enable) begin
      div_next = 16'h0000; // Restart from centre so the pattern starts clean
      off_next = 8'sh00;
      up_next = 1'b1;
    end else if (div_reg == 16'(STEP_CYC - 1)) begin
      div_next = 16'h0000;
      if (up_reg) begin
        off_next = off_reg + 8'sh01;
        if (off_reg == AMP - 8'sh01) begin
          up_next = 1'b0;
        end
      end else begin
        off_next = off_reg - 8'sh01;
        if (off_reg == -AMP + 8'sh01) begin
          up_next = 1'b1;
        end
      end
    end else begin
      div_next = div_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= 16'h0000;
      off_reg <= 8'sh00;
      up_reg <= 1'b1;
    end else begin
      div_reg <= div_next;
      off_reg <= off_next;
      up_reg <= up_next;
    end
  end

  assign offset = off_reg;
endmodule

/* pcpt_core_chk.sv */
// Port-level assertions for the pulse-width timing core
`timescale 1ns/10ps
module pcpt_core_chk (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic current_above_feedback,
  input wire logic peak_current_limit_trip,
  input wire logic soft_start_done,
  input wire logic burst_low_power_mode,
  input wire logic [3:0] feedback_level,
  input wire logic gate_drive,
  input wire logic slope_comp_active,
  input wire logic [11:0] slope_ramp,
  input wire logic limit_curve_high_duty,
  input wire logic prop_comp_reduced,
  input wire logic jitter_active
);
  logic [11:0] on_cnt_reg, on_cnt_next, since_reg, since_next;
  logic gate_prev_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////
  // High-time and rise-to-rise counters; rises come every period, so no wrap
  always_comb begin
    on_cnt_next = gate_drive ? on_cnt_reg + 12'h001 : 12'h000;
    since_next = (gate_drive && !gate_prev_reg) ? 12'h001 : since_reg + 12'h001;
  end
  // Counter registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      on_cnt_reg <= 12'h000;
      since_reg <= 12'h000;
      gate_prev_reg <= 1'b0;
    end else begin
      on_cnt_reg <= on_cnt_next;
      since_reg <= since_next;
      gate_prev_reg <= gate_drive;
    end
  end
  ////////////////////////////////////////////////////////////
  // A trip past blanking, held long enough to clear the synchroniser
  sequence s_pwm_trip;
    $rose(current_above_feedback) && gate_drive && on_cnt_reg >= 12'h01e
      ##1 current_above_feedback[*5];
  endsequence
  sequence s_lim_trip;
    $rose(peak_current_limit_trip) && gate_drive && on_cnt_reg >= 12'h01e
      ##1 peak_current_limit_trip[*5];
  endsequence
  property p_min_on; $fell(gate_drive) |-> on_cnt_reg >= 12'h01e; endproperty
  a_min_on: assert property (p_min_on) else $error("pulse shorter than blanking");
  property p_max_duty; gate_drive |-> on_cnt_reg <= 12'h470; endproperty
  a_max_duty: assert property (p_max_duty) else $error("pulse past max duty");
  property p_period;
    $rose(gate_drive) |-> since_reg >= 12'h3b6 && since_reg <= 12'h618;
  endproperty
  a_period: assert property (p_period) else $error("gate rise off the period");
  property p_pwm_trip; s_pwm_trip |=> !gate_drive; endproperty
  a_pwm_trip: assert property (p_pwm_trip) else $error("trip did not end pulse");
  property p_lim_trip; s_lim_trip |=> !gate_drive; endproperty
  a_lim_trip: assert property (p_lim_trip) else $error("limit did not end pulse");
  property p_slope_win;
    slope_comp_active |-> gate_drive && on_cnt_reg >= 12'h12c;
  endproperty
  a_slope_win: assert property (p_slope_win) else $error("slope too early");
  property p_ramp_zero; !slope_comp_active |-> slope_ramp == 12'h000; endproperty
  a_ramp_zero: assert property (p_ramp_zero) else $error("ramp while inactive");
  property p_ramp_grow;
    slope_comp_active && $past(slope_comp_active) |-> slope_ramp == $past(slope_ramp) + 12'h001;
  endproperty
  a_ramp_grow: assert property (p_ramp_grow) else $error("ramp not growing");
  property p_curve; slope_comp_active |-> limit_curve_high_duty; endproperty
  a_curve: assert property (p_curve) else $error("wrong limit curve");
  property p_burst;
    burst_low_power_mode[*7] |-> prop_comp_reduced;
  endproperty
  a_burst: assert property (p_burst) else $error("compensation not reduced");
  property p_jit_off; !soft_start_done[*8] |-> !jitter_active; endproperty
  a_jit_off: assert property (p_jit_off) else $error("jitter during soft-start");
endmodule

/* pcpt_fet_model.sv */
// Behavioural power switch and sense resistor: current ramps while the gate is on
`timescale 1ns/10ps
module pcpt_fet_model (
  input wire logic clk_sys,
  input wire logic gate_drive,
  input wire logic [11:0] trip_at,
  input wire logic [11:0] limit_at,
  output logic current_above_feedback = 1'b0,
  output logic peak_current_limit_trip = 1'b0
);
  logic [11:0] ramp_reg = 12'h000;
  // Current collapses when the switch opens, so both comparators drop with it
  always @(posedge clk_sys) begin
    ramp_reg <= gate_drive ? ramp_reg + 12'h001 : 12'h000;
    current_above_feedback <= gate_drive && ramp_reg >= trip_at;
    peak_current_limit_trip <= gate_drive && ramp_reg >= limit_at;
  end
endmodule

/* pcpt_core_tb.sv */
// Self-checking bench for the pulse-width timing core
`timescale 1ns/10ps
module pcpt_core_tb;
  typedef struct {int lo; int hi; int rlo; int rhi;} pcpt_note_type;
  pcpt_note_type notes[$];
  pcpt_note_type n;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic soft_start_done = 1'b0;
  logic burst_low_power_mode = 1'b0;
  logic [3:0] feedback_level = 4'hf;
  logic [11:0] trip_at = 12'hfff;
  logic [11:0] limit_at = 12'hfff;
  logic current_above_feedback, peak_current_limit_trip, gate_drive, slope_comp_active;
  logic limit_curve_high_duty, prop_comp_reduced, jitter_active;
  logic [11:0] slope_ramp, last_ramp;
  int miscompares = 0;
  int n_tests = 0;
  int width = 0;
  int codes[4] = '{0, 3, 5, 7};
  int t, p, d, r;
  always #5 clk_sys = ~clk_sys;
  // Short soft-start and jitter counts keep the run brief
  pcpt_core #(.SS_CYCLES(2000), .JIT_CYCLES(16000)) pcpt_core_inst (.clk_sys(clk_sys),
    .arst_n(arst_n), .current_above_feedback(current_above_feedback),
    .peak_current_limit_trip(peak_current_limit_trip), .soft_start_done(soft_start_done),
    .burst_low_power_mode(burst_low_power_mode), .feedback_level(feedback_level),
    .gate_drive(gate_drive), .slope_comp_active(slope_comp_active), .slope_ramp(slope_ramp),
    .limit_curve_high_duty(limit_curve_high_duty), .prop_comp_reduced(prop_comp_reduced),
    .jitter_active(jitter_active));
  pcpt_fet_model pcpt_fet_model_inst (.clk_sys(clk_sys), .gate_drive(gate_drive),
    .trip_at(trip_at), .limit_at(limit_at), .current_above_feedback(current_above_feedback),
    .peak_current_limit_trip(peak_current_limit_trip));
  ////////////////////////////////////////////////////////////
  // Count a comparison and report it at once if it misses
  task chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // Verdict and end of run
  task end_sim;
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One period: arm the sense model, note the expected shape, ride it out
  task pulse(input int tr, input int lm, input int lo, input int hi, input int rlo,
    input int rhi);
    int k;
    @(posedge clk_sys);
    trip_at <= 12'(tr);
    limit_at <= 12'(lm);
    notes.push_back('{lo, hi, rlo, rhi});
    k = 0;
    while (gate_drive !== 1'b1 && k < 3000) begin
      @(posedge clk_sys);
      k++;
    end
    // A gate that never rises must fail too, not slip past the second wait
    if (k >= 3000) miscompares++;
    while (gate_drive !== 1'b0 && k < 6000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 6000) miscompares++;
  endtask
  // Measure each pulse; a pulse with no note is itself a mismatch
  always @(posedge clk_sys) begin
    if (gate_drive === 1'b1) begin
      width <= width + 1;
      last_ramp <= slope_ramp;
    end else if (width > 0) begin
      width <= 0;
      chk(notes.size() > 0, "unexpected pulse");
      if (notes.size() > 0) begin
        n = notes.pop_front();
        chk(width >= n.lo && width <= n.hi, "pulse width");
        chk(last_ramp >= n.rlo && last_ramp <= n.rhi, "slope ramp");
      end
    end
  end
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(32'h913d2686));
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    pulse(4095, 4095, 749, 751, 347, 351);
    chk(limit_curve_high_duty === 1'b1, "high-duty curve");
    for (int i = 0; i < 4; i++) begin
      t = 40 + $urandom % 260;
      pulse(t, 4095, t + 3, t + 8, 0, 0);
      pulse(4095, t, t + 3, t + 8, 0, 0);
    end
    pulse(0, 4095, 30, 32, 0, 0);
    pulse(4095, 0, 30, 32, 0, 0);
    chk(limit_curve_high_duty === 1'b0, "low-duty curve");
    // Lower codes stretch the period up to the floor; the first pulse only settles it
    for (int i = 0; i < 4; i++) begin
      feedback_level <= 4'(codes[i]);
      p = (codes[i] >= 7) ? 1000 : 1000 + (7 - codes[i]) * 100;
      p = (p > 1515) ? 1515 : p;
      d = p * 3 / 4;
      r = d - p * 2 / 5;
      pulse(4095, 4095, 0, 4095, 0, 4095);
      pulse(4095, 4095, d - 1, d + 1, r - 3, r + 1);
    end
    feedback_level <= 4'hf;
    burst_low_power_mode <= 1'b1;
    pulse(4095, 4095, 0, 4095, 0, 4095);
    pulse(4095, 4095, 749, 751, 0, 0);
    chk(prop_comp_reduced === 1'b1, "compensation level");
    burst_low_power_mode <= 1'b0;
    chk(jitter_active === 1'b0, "jitter before start");
    soft_start_done <= 1'b1;
    repeat (3) pulse(4095, 4095, 0, 4095, 0, 4095);
    chk(jitter_active === 1'b1, "jitter after start");
    chk(prop_comp_reduced === 1'b0, "full compensation");
    // Offset is still on its rising ramp here, so an unjittered 750 must fail
    pulse(4095, 4095, 760, 781, 350, 365);
    // Let the monitor score the last pulse before the verdict
    repeat (2) @(posedge clk_sys);
    end_sim();
  end
  // Watchdog sized at about twice the expected run
  initial begin
    #600000;
    miscompares++;
    end_sim();
  end
endmodule
bind pcpt_core pcpt_core_chk pcpt_core_chk_inst (.clk_sys(clk_sys), .arst_n(arst_n),
  .current_above_feedback(current_above_feedback),
  .peak_current_limit_trip(peak_current_limit_trip), .soft_start_done(soft_start_done),
  .burst_low_power_mode(burst_low_power_mode), .feedback_level(feedback_level),
  .gate_drive(gate_drive), .slope_comp_active(slope_comp_active), .slope_ramp(slope_ramp),
  .limit_curve_high_duty(limit_curve_high_duty), .prop_comp_reduced(prop_comp_reduced),
  .jitter_active(jitter_active));
